/* hdl/pwr_mode_pkg.sv */
/*
 Shared constants for the operating-mode controller: register offsets,
 field positions, reset values, mode and policy encodings.
 Assumes nothing of its surroundings.
*/
package pwr_mode_pkg;

    // ------------------------------------------------------------
    // Modes, ordered by falling power draw
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_RUN      = 3'h0,
        MODE_SLEEP    = 3'h1,
        MODE_STOP     = 3'h3,
        MODE_STANDBY  = 3'h2,
        MODE_SHUTDOWN = 3'h6
    } mode_t;

    typedef enum logic [1:0] {
        SEQ_ACTIVE = 2'h0,
        SEQ_ENTER  = 2'h1,
        SEQ_LOW    = 2'h3,
        SEQ_WAKE   = 2'h2
    } seq_t;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_MODE_CTRL  = 8'h00;
    localparam logic [7:0] OFS_RUN_POLICY = 8'h04;
    localparam logic [7:0] OFS_STATUS     = 8'h08;
    localparam logic [7:0] OFS_FUNC_EN    = 8'h0c;
    localparam logic [7:0] OFS_PD0_CFG    = 8'h10;
    localparam logic [7:0] OFS_PD1_CFG    = 8'h14;
    localparam logic [7:0] OFS_BAT_CFG    = 8'h18;

    // Mode control fields
    localparam int MC_MODE_LSB = 0;
    localparam int MC_POL_LSB  = 4;

    // Policy counts per mode
    localparam logic [1:0] RUN_POLICIES     = 2'h3;
    localparam logic [1:0] SLEEP_POLICIES   = 2'h3;
    localparam logic [1:0] STOP_POLICIES    = 2'h3;
    localparam logic [1:0] STANDBY_POLICIES = 2'h2;

    // Run, STOP and STANDBY policy codes
    localparam logic [1:0] RUN_FULL_SPEED_POLICY    = 2'h0;
    localparam logic [1:0] RUN_SLOW_CLOCK_OSC_ON    = 2'h1;
    localparam logic [1:0] RUN_SLOW_CLOCK_OSC_OFF   = 2'h2;
    localparam logic [1:0] STOP_FIRST_POLICY        = 2'h0;
    localparam logic [1:0] STANDBY_TIMERS_CLOCKED   = 2'h1;

    // Low-speed domain clock rate codes
    localparam logic [1:0] CLK_OFF  = 2'h0;
    localparam logic [1:0] CLK_32K  = 2'h1;
    localparam logic [1:0] CLK_4M   = 2'h2;
    localparam logic [1:0] CLK_FAST = 2'h3;

    // Reset values
    localparam logic [31:0] RST_CFG     = 32'h0000_0000;
    localparam logic [7:0]  RST_FUNC_EN = 8'h00;

    // Status fields
    localparam int ST_MODE_LSB = 0;
    localparam int ST_POL_LSB  = 4;
    localparam int ST_SEQ_LSB  = 8;

    localparam int NUM_FUNC = 8;

endpackage

/* hdl/retention_regs.sv */
/*
 Small register store for one power domain's configuration words.
 Cleared by its own power-off strobe; read data is registered.
 Assumes one clock and a synchronous write port.
*/
`timescale 1ns/1ps
module retention_regs #(
    parameter int DEPTH = 2
) (
    input  wire logic                     clk,
    input  wire logic                     rst_b,
    input  wire logic                     power_off,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] addr,
    input  wire logic [31:0]              wr_data,
    output logic      [31:0]              rd_data
);

    logic [31:0] mem_q [DEPTH];

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++)
        begin : g_word
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                    mem_q[i] <= pwr_mode_pkg::RST_CFG;
                else if (power_off)
                    mem_q[i] <= pwr_mode_pkg::RST_CFG;
                else if (wr_en && addr == i)
                    mem_q[i] <= wr_data;
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rd_data <= pwr_mode_pkg::RST_CFG;
        else
            rd_data <= mem_q[addr];
    end

endmodule // retention_regs

/* hdl/power_mode_domain_control.sv */
/*
 Operating-mode controller: sequences RUN, SLEEP, STOP, STANDBY and
 SHUTDOWN, gates the processor and domain clocks, powers the domains.
 Assumes an APB master on clk, synchronous wake inputs and a sleep
 request pulse from the processor.
*/
// Chosen here: the APB interface to the registers and the address map.
// Notes on behaviour
// - Five modes, RUN down to SHUTDOWN.
// - Processor clocked only in RUN.
// - Interrupt wakes; low modes need low-domain interrupt.
// - SHUTDOWN regulator off; pin, debug, IO wake.
// - Three policies RUN/SLEEP/STOP, two STANDBY.
// - Fast domain powered only in RUN, SLEEP.
// - Low domain powered except SHUTDOWN.
// - Battery island always on.
// - Disabled functions gated, configuration kept.
// - Off functions lose configuration, reset values.
// - Optional functions keep running if enabled.
// - First STOP from osc-on slow RUN keeps oscillator.
// - First STOP from osc-off slow RUN keeps oscillator off.
// - Timers-clocked STANDBY clocks timers and RTC.
// - Other low peripherals unclocked, may request clock.
// - Converter/IO registers need fast domain.
`timescale 1ns/1ps
module power_mode_domain_control #(
    parameter int NUM_FUNC = pwr_mode_pkg::NUM_FUNC
) (
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic                     pready,
    output logic      [31:0]         prdata,
    output logic                     pslverr,
    input  wire logic                sleep_request,
    input  wire logic                any_irq,
    input  wire logic                low_domain_irq,
    input  wire logic                external_reset_pin,
    input  wire logic                debug_activity,
    input  wire logic                io_wake_match,
    input  wire logic                fast_clock_request,
    output logic                     processor_clock_en,
    output logic                     high_performance_domain_on,
    output logic                     low_speed_domain_on,
    output logic                     battery_island_domain_on,
    output logic                     core_regulator_on,
    output logic                     internal_fast_oscillator_en,
    output logic      [1:0]          low_speed_domain_clock,
    output logic                     timer_instances_clk_en,
    output logic                     rtc_clk_en,
    output logic      [NUM_FUNC-1:0] func_clk_en
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    pwr_mode_pkg::mode_t mode_q, mode_d, target_q;
    pwr_mode_pkg::seq_t  seq_q, seq_d;
    logic [1:0]          tgt_pol_q, pol_q, pol_d;
    logic [1:0]          run_pol_q;
    logic [NUM_FUNC-1:0] func_en_q;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire setup    = psel && !penable;
    wire access   = psel && penable;
    wire wr       = access && pwrite;
    wire sel_mc   = paddr == pwr_mode_pkg::OFS_MODE_CTRL;
    wire sel_run  = paddr == pwr_mode_pkg::OFS_RUN_POLICY;
    wire sel_st   = paddr == pwr_mode_pkg::OFS_STATUS;
    wire sel_fe   = paddr == pwr_mode_pkg::OFS_FUNC_EN;
    wire sel_pd0  = paddr == pwr_mode_pkg::OFS_PD0_CFG;
    wire sel_pd1  = paddr == pwr_mode_pkg::OFS_PD1_CFG;
    wire sel_bat  = paddr == pwr_mode_pkg::OFS_BAT_CFG;
    wire sel_cfg  = sel_pd0 || sel_pd1 || sel_bat;
    wire mapped   = sel_mc || sel_run || sel_st || sel_fe || sel_cfg;

    // Registers sit in the fast domain: no access unless it is powered
    // register access gating
    wire bus_ok   = high_performance_domain_on;
    wire bus_err  = !mapped || !bus_ok;

    wire [2:0] wr_mode = pwdata[pwr_mode_pkg::MC_MODE_LSB +: 3];
    wire [1:0] wr_pol  = pwdata[pwr_mode_pkg::MC_POL_LSB +: 2];

    wire [1:0] pol_limit =
        (wr_mode == pwr_mode_pkg::MODE_SLEEP)   ? pwr_mode_pkg::SLEEP_POLICIES :
        (wr_mode == pwr_mode_pkg::MODE_STOP)    ? pwr_mode_pkg::STOP_POLICIES :
        (wr_mode == pwr_mode_pkg::MODE_STANDBY) ? pwr_mode_pkg::STANDBY_POLICIES :
        (wr_mode == pwr_mode_pkg::MODE_SHUTDOWN) ? 2'h1 : pwr_mode_pkg::RUN_POLICIES;
    // only the five modes are accepted
    wire mode_ok  = wr_mode == pwr_mode_pkg::MODE_RUN || wr_mode == pwr_mode_pkg::MODE_SLEEP
                 || wr_mode == pwr_mode_pkg::MODE_STOP || wr_mode == pwr_mode_pkg::MODE_STANDBY
                 || wr_mode == pwr_mode_pkg::MODE_SHUTDOWN;
    wire mc_ok    = mode_ok && wr_pol < pol_limit;
    wire run_ok   = pwdata[1:0] < pwr_mode_pkg::RUN_POLICIES;

    // ------------------------------------------------------------
    // Domain configuration stores
    // ------------------------------------------------------------
    wire [31:0] pd0_rd, pd1_rd, bat_rd;
    wire        pd0_off = !low_speed_domain_on;
    wire        pd1_off = !high_performance_domain_on;

    // unpowered stores return to reset values
    retention_regs #(.DEPTH(2)) u_pd0_regs (
        .clk       (clk),
        .rst_b     (rst_b),
        .power_off (pd0_off),
        .wr_en     (wr && sel_pd0 && bus_ok),
        .addr      (1'b0),
        .wr_data   (pwdata),
        .rd_data   (pd0_rd)
    );
    retention_regs #(.DEPTH(2)) u_pd1_regs (
        .clk       (clk),
        .rst_b     (rst_b),
        .power_off (pd1_off),
        .wr_en     (wr && sel_pd1 && bus_ok),
        .addr      (1'b0),
        .wr_data   (pwdata),
        .rd_data   (pd1_rd)
    );
    retention_regs #(.DEPTH(2)) u_bat_regs (
        .clk       (clk),
        .rst_b     (rst_b),
        .power_off (1'b0),
        .wr_en     (wr && sel_bat && bus_ok),
        .addr      (1'b0),
        .wr_data   (pwdata),
        .rd_data   (bat_rd)
    );

    wire [31:0] status_word = {20'h0, 2'h0, seq_q, 2'h0, pol_q, 1'b0, mode_q};
    wire [31:0] rd_mux =
        sel_mc  ? {26'h0, tgt_pol_q, 1'b0, target_q} :
        sel_run ? {30'h0, run_pol_q} :
        sel_st  ? status_word :
        sel_fe  ? {{(32-NUM_FUNC){1'b0}}, func_en_q} :
        sel_pd0 ? pd0_rd :
        sel_pd1 ? pd1_rd :
        sel_bat ? bat_rd : 32'h0;

    // Ready one cycle after setup so the store reads have settled
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= setup;
            pslverr <= setup && bus_err;
            prdata  <= (setup && !bus_err && !pwrite) ? rd_mux : 32'h0;
        end
    end

    // Writes land at the edge where pready is sampled high
    wire wr_take = wr && pready && bus_ok;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            target_q  <= pwr_mode_pkg::MODE_RUN;
            tgt_pol_q <= 2'h0;
            run_pol_q <= pwr_mode_pkg::RUN_FULL_SPEED_POLICY;
            func_en_q <= pwr_mode_pkg::RST_FUNC_EN[NUM_FUNC-1:0];
        end
        else
        begin
            if (wr_take && sel_mc && mc_ok)
            begin
                target_q  <= pwr_mode_pkg::mode_t'(wr_mode);
                tgt_pol_q <= wr_pol;
            end
            if (wr_take && sel_run && run_ok)
                run_pol_q <= pwdata[1:0];
            if (wr_take && sel_fe)
                func_en_q <= pwdata[NUM_FUNC-1:0];
        end
    end

    // ------------------------------------------------------------
    // Mode sequencer
    // ------------------------------------------------------------
    // wake qualification per mode
    wire irq_wake = (mode_q == pwr_mode_pkg::MODE_SLEEP && any_irq)
                 || ((mode_q == pwr_mode_pkg::MODE_STOP || mode_q == pwr_mode_pkg::MODE_STANDBY)
                     && low_domain_irq);
    // only pin, debug or IO match leave SHUTDOWN
    wire sd_wake  = mode_q == pwr_mode_pkg::MODE_SHUTDOWN
                 && (external_reset_pin || debug_activity || io_wake_match);

    always_comb
    begin
        mode_d = mode_q;
        pol_d  = pol_q;
        seq_d  = seq_q;
        case (seq_q)
            // leave RUN only on a sleep request with a target chosen
            pwr_mode_pkg::SEQ_ACTIVE:
                if (sleep_request && target_q != pwr_mode_pkg::MODE_RUN)
                    seq_d = pwr_mode_pkg::SEQ_ENTER;
            pwr_mode_pkg::SEQ_ENTER:
            begin
                mode_d = target_q;
                pol_d  = tgt_pol_q;
                seq_d  = pwr_mode_pkg::SEQ_LOW;
            end
            pwr_mode_pkg::SEQ_LOW:
                if (irq_wake || sd_wake)
                    seq_d = pwr_mode_pkg::SEQ_WAKE;
            pwr_mode_pkg::SEQ_WAKE:
            begin
                mode_d = pwr_mode_pkg::MODE_RUN;
                pol_d  = run_pol_q;
                seq_d  = pwr_mode_pkg::SEQ_ACTIVE;
            end
            default:
                seq_d = pwr_mode_pkg::SEQ_ACTIVE;
        endcase
        if (seq_q == pwr_mode_pkg::SEQ_ACTIVE)
            pol_d = run_pol_q;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mode_q <= pwr_mode_pkg::MODE_RUN;
            pol_q  <= pwr_mode_pkg::RUN_FULL_SPEED_POLICY;
            seq_q  <= pwr_mode_pkg::SEQ_ACTIVE;
        end
        else
        begin
            mode_q <= mode_d;
            pol_q  <= pol_d;
            seq_q  <= seq_d;
        end
    end

    // Policy of RUN at the moment of entry, kept for the first STOP policy
    logic [1:0] entry_run_pol_q;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            entry_run_pol_q <= pwr_mode_pkg::RUN_FULL_SPEED_POLICY;
        else if (seq_q == pwr_mode_pkg::SEQ_ACTIVE)
            entry_run_pol_q <= run_pol_q;
    end

    // ------------------------------------------------------------
    // Domain, clock and oscillator controls
    // ------------------------------------------------------------
    wire m_run   = mode_d == pwr_mode_pkg::MODE_RUN;
    wire m_sleep = mode_d == pwr_mode_pkg::MODE_SLEEP;
    wire m_stop  = mode_d == pwr_mode_pkg::MODE_STOP;
    wire m_stby  = mode_d == pwr_mode_pkg::MODE_STANDBY;
    wire m_sd    = mode_d == pwr_mode_pkg::MODE_SHUTDOWN;
    wire stop_first_policy   = m_stop && pol_d == pwr_mode_pkg::STOP_FIRST_POLICY;
    wire from_r1 = entry_run_pol_q == pwr_mode_pkg::RUN_SLOW_CLOCK_OSC_ON;
    wire from_r2 = entry_run_pol_q == pwr_mode_pkg::RUN_SLOW_CLOCK_OSC_OFF;
    wire stby1   = m_stby && pol_d == pwr_mode_pkg::STANDBY_TIMERS_CLOCKED;
    // Slow clock policies: policy 1 and 2 of RUN and SLEEP
    wire slow    = (m_run || m_sleep) && pol_d != 2'h0;

    // oscillator stays on after osc-on slow RUN
    // oscillator stays off after osc-off slow RUN
    wire osc_d   = ((m_run || m_sleep) && pol_d != 2'h2)
                || (stop_first_policy && !from_r2)
                || (m_stop && pol_d == 2'h1);

    wire [1:0] lsclk_d =
        m_sd                                  ? pwr_mode_pkg::CLK_OFF :
        m_stby                                ? pwr_mode_pkg::CLK_OFF :
        (stop_first_policy && (from_r1 || from_r2))       ? pwr_mode_pkg::CLK_32K :
        (m_stop && pol_d == 2'h2)             ? pwr_mode_pkg::CLK_32K :
        m_stop                                ? pwr_mode_pkg::CLK_4M :
        slow                                  ? pwr_mode_pkg::CLK_32K : pwr_mode_pkg::CLK_FAST;

    // disabled functions gated in low modes, store untouched
    // in STANDBY unclocked unless they raise a fast clock request
    wire [NUM_FUNC-1:0] fclk_d =
        (m_run || m_sleep || m_stop) ? func_en_q :
        (m_stby && fast_clock_request) ? func_en_q : {NUM_FUNC{1'b0}};

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            processor_clock_en          <= 1'b1;
            high_performance_domain_on  <= 1'b1;
            low_speed_domain_on         <= 1'b1;
            battery_island_domain_on    <= 1'b1;
            core_regulator_on           <= 1'b1;
            internal_fast_oscillator_en <= 1'b1;
            low_speed_domain_clock      <= pwr_mode_pkg::CLK_FAST;
            timer_instances_clk_en      <= 1'b1;
            rtc_clk_en                  <= 1'b1;
            func_clk_en                 <= {NUM_FUNC{1'b0}};
        end
        else
        begin
            processor_clock_en          <= m_run;
            // fast domain in RUN and SLEEP
            high_performance_domain_on  <= m_run || m_sleep;
            // low domain off only in SHUTDOWN
            low_speed_domain_on         <= !m_sd;
            battery_island_domain_on    <= 1'b1;
            core_regulator_on           <= !m_sd;
            internal_fast_oscillator_en <= osc_d;
            low_speed_domain_clock      <= lsclk_d;
            // timers and RTC clocked in timers-clocked STANDBY
            timer_instances_clk_en      <= !m_sd && (!m_stby || stby1);
            rtc_clk_en                  <= 1'b1;
            func_clk_en                 <= fclk_d;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_cpu_run_only: assert property (@(posedge clk) disable iff (!rst_b)
        processor_clock_en |-> mode_q == pwr_mode_pkg::MODE_RUN)
        else $error("processor clocked outside RUN");

    a_fast_dom_mode: assert property (@(posedge clk) disable iff (!rst_b)
        high_performance_domain_on == (mode_q == pwr_mode_pkg::MODE_RUN || mode_q == pwr_mode_pkg::MODE_SLEEP))
        else $error("fast domain power wrong for mode");

    a_low_dom_sd: assert property (@(posedge clk) disable iff (!rst_b)
        low_speed_domain_on != (mode_q == pwr_mode_pkg::MODE_SHUTDOWN))
        else $error("low domain power wrong for mode");

    a_island_on: assert property (@(posedge clk) disable iff (!rst_b)
        battery_island_domain_on && rtc_clk_en)
        else $error("island domain dropped");

    a_sd_wake_src: assert property (@(posedge clk) disable iff (!rst_b)
        (mode_q == pwr_mode_pkg::MODE_SHUTDOWN && seq_q == pwr_mode_pkg::SEQ_LOW
         && !external_reset_pin && !debug_activity && !io_wake_match)
        |=> mode_q == pwr_mode_pkg::MODE_SHUTDOWN && !core_regulator_on)
        else $error("shutdown left without valid source");

    a_stop_wake_irq: assert property (@(posedge clk) disable iff (!rst_b)
        (seq_q == pwr_mode_pkg::SEQ_LOW && mode_q == pwr_mode_pkg::MODE_STOP && low_domain_irq)
        |-> ##2 mode_q == pwr_mode_pkg::MODE_RUN && processor_clock_en)
        else $error("low-domain interrupt did not wake STOP");

    a_entry_needs_req: assert property (@(posedge clk) disable iff (!rst_b)
        (mode_q == pwr_mode_pkg::MODE_RUN && seq_q == pwr_mode_pkg::SEQ_ACTIVE && !sleep_request)
        |=> mode_q == pwr_mode_pkg::MODE_RUN)
        else $error("mode left without sleep request");

    a_stop_first_policy_osc_off: assert property (@(posedge clk) disable iff (!rst_b)
        (mode_q == pwr_mode_pkg::MODE_STOP && pol_q == pwr_mode_pkg::STOP_FIRST_POLICY
         && entry_run_pol_q == pwr_mode_pkg::RUN_SLOW_CLOCK_OSC_OFF)
        |-> !internal_fast_oscillator_en && low_speed_domain_clock == pwr_mode_pkg::CLK_32K)
        else $error("first STOP policy changed clocks");

    a_stby_timers: assert property (@(posedge clk) disable iff (!rst_b)
        (mode_q == pwr_mode_pkg::MODE_STANDBY)
        |-> timer_instances_clk_en == (pol_q == pwr_mode_pkg::STANDBY_TIMERS_CLOCKED))
        else $error("standby timer clock wrong");

endmodule // power_mode_domain_control

/* tb/power_mode_domain_control_bench.sv */
/*
 Self-checking bench for the operating-mode controller.
 Assumes the design's hand-over contract: zero-wait APB slave, two-edge mode entry and wake.
*/
`timescale 1ns/1ps
module power_mode_domain_control_bench;
    logic        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        sleep_request = 1'b0, fast_clock_request = 1'b0, er;
    logic [4:0]  wk = 5'h00;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd, seed = 32'h5e44f028, v0, v1, v2;
    int          fails = 0, tests_run = 0;
    wire         pready, pslverr, pce, hp_on, ls_on, bat_on, reg_on, osc_en, tmr_en, rtc_en;
    wire  [31:0] prdata;
    wire  [1:0]  ls_clk;
    wire  [7:0]  fce;
    // Wake lines: 0 any irq, 1 low-domain irq, 2 reset pin, 3 debug, 4 io match
    power_mode_domain_control dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .sleep_request(sleep_request), .any_irq(wk[0]), .low_domain_irq(wk[1]),
        .external_reset_pin(wk[2]), .debug_activity(wk[3]), .io_wake_match(wk[4]),
        .fast_clock_request(fast_clock_request), .processor_clock_en(pce),
        .high_performance_domain_on(hp_on), .low_speed_domain_on(ls_on),
        .battery_island_domain_on(bat_on), .core_regulator_on(reg_on),
        .internal_fast_oscillator_en(osc_en), .low_speed_domain_clock(ls_clk),
        .timer_instances_clk_en(tmr_en), .rtc_clk_en(rtc_en), .func_clk_en(fce));
    always #50 clk = ~clk;
    // ------------------------------------------------------------
    // Expectation and stimulus helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] outs(pwr_mode_pkg::mode_t m);
        return {27'h0, m == pwr_mode_pkg::MODE_RUN,
                m == pwr_mode_pkg::MODE_RUN || m == pwr_mode_pkg::MODE_SLEEP,
                m != pwr_mode_pkg::MODE_SHUTDOWN, 1'b1, m != pwr_mode_pkg::MODE_SHUTDOWN};
    endfunction
    task automatic end_sim();
        if (fails == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Holds the request until pready is seen high at a rising edge
    // Starts on a rising edge, so back-to-back calls leave one idle cycle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        if (n == 20)
            chk(32'h1, 32'h0);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic enter(input pwr_mode_pkg::mode_t m, input logic [1:0] pol);
        apb(1'b1, pwr_mode_pkg::OFS_MODE_CTRL, {26'h0, pol, 1'b0, m});
        sleep_request <= 1'b1;
        @(posedge clk);
        sleep_request <= 1'b0;
        for (int n = 0; n < 8 && pce !== 1'b0; n++)
            @(negedge clk);
        chk({27'h0, pce, hp_on, ls_on, bat_on, reg_on}, outs(m));
    endtask
    // A refused wake source is held long enough that a slow accept would still show
    task automatic wake(input int k, input logic ok);
        @(posedge clk);
        wk <= 5'h01 << k;
        for (int n = 0; n < 6 && pce !== 1'b1; n++)
            @(negedge clk);
        @(posedge clk);
        wk <= 5'h00;
        chk({31'h0, pce}, {31'h0, ok});
        if (ok)
            chk({27'h0, pce, hp_on, ls_on, bat_on, reg_on}, outs(pwr_mode_pkg::MODE_RUN));
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk({27'h0, pce, hp_on, ls_on, bat_on, reg_on}, outs(pwr_mode_pkg::MODE_RUN));
        rdchk(pwr_mode_pkg::OFS_PD1_CFG, pwr_mode_pkg::RST_CFG);
        apb(1'b0, 8'h1c, 32'h0);
        chk({31'h0, er}, 32'h1);
        v0 = rnd(); v1 = rnd(); v2 = rnd();
        apb(1'b1, pwr_mode_pkg::OFS_PD1_CFG, v0);
        apb(1'b1, pwr_mode_pkg::OFS_PD0_CFG, v1);
        apb(1'b1, pwr_mode_pkg::OFS_BAT_CFG, v2);
        apb(1'b1, pwr_mode_pkg::OFS_FUNC_EN, v2);
        // Function clocks follow the enable register one edge after the write
        repeat (2) @(negedge clk);
        chk({24'h0, fce}, {24'h0, v2[7:0]});
        enter(pwr_mode_pkg::MODE_SLEEP, 2'(rnd() % 3));
        rdchk(pwr_mode_pkg::OFS_PD1_CFG, v0);
        wake(0, 1'b1);
        apb(1'b1, pwr_mode_pkg::OFS_RUN_POLICY, {30'h0, pwr_mode_pkg::RUN_SLOW_CLOCK_OSC_ON});
        enter(pwr_mode_pkg::MODE_STOP, pwr_mode_pkg::STOP_FIRST_POLICY);
        chk({29'h0, osc_en, ls_clk}, {29'h0, 1'b1, pwr_mode_pkg::CLK_32K});
        apb(1'b1, pwr_mode_pkg::OFS_PD1_CFG, v1);
        chk({31'h0, er}, 32'h1);
        wake(0, 1'b0);
        wake(1, 1'b1);
        rdchk(pwr_mode_pkg::OFS_PD1_CFG, pwr_mode_pkg::RST_CFG);
        rdchk(pwr_mode_pkg::OFS_PD0_CFG, v1);
        apb(1'b1, pwr_mode_pkg::OFS_RUN_POLICY, {30'h0, pwr_mode_pkg::RUN_SLOW_CLOCK_OSC_OFF});
        enter(pwr_mode_pkg::MODE_STOP, pwr_mode_pkg::STOP_FIRST_POLICY);
        chk({29'h0, osc_en, ls_clk}, {29'h0, 1'b0, pwr_mode_pkg::CLK_32K});
        wake(1, 1'b1);
        enter(pwr_mode_pkg::MODE_STANDBY, pwr_mode_pkg::STANDBY_TIMERS_CLOCKED);
        chk({30'h0, tmr_en, rtc_en}, 32'h3);
        chk({24'h0, fce}, 32'h0);
        @(posedge clk);
        fast_clock_request <= 1'b1;
        repeat (2) @(negedge clk);
        chk({24'h0, fce}, {24'h0, v2[7:0]});
        @(posedge clk);
        fast_clock_request <= 1'b0;
        wake(0, 1'b0);
        wake(1, 1'b1);
        enter(pwr_mode_pkg::MODE_STANDBY, 2'h0);
        chk({30'h0, tmr_en, rtc_en}, 32'h1);
        wake(1, 1'b1);
        enter(pwr_mode_pkg::MODE_STOP, 2'h1);
        chk({29'h0, osc_en, ls_clk}, {29'h0, 1'b1, pwr_mode_pkg::CLK_4M});
        wake(1, 1'b1);
        enter(pwr_mode_pkg::MODE_STOP, 2'h2);
        chk({29'h0, osc_en, ls_clk}, {29'h0, 1'b0, pwr_mode_pkg::CLK_32K});
        wake(1, 1'b1);
        for (int k = 2; k < 5; k++)
        begin
            enter(pwr_mode_pkg::MODE_SHUTDOWN, 2'h0);
            wake(1, 1'b0);
            wake(k, 1'b1);
        end
        rdchk(pwr_mode_pkg::OFS_PD0_CFG, pwr_mode_pkg::RST_CFG);
        rdchk(pwr_mode_pkg::OFS_BAT_CFG, v2);
        apb(1'b1, pwr_mode_pkg::OFS_MODE_CTRL, 32'h0);
        sleep_request <= 1'b1;
        @(posedge clk);
        sleep_request <= 1'b0;
        repeat (4) @(negedge clk);
        chk({31'h0, pce}, 32'h1);
        end_sim();
    end
    // Hang guard, well beyond the few hundred cycles the sequence needs
    initial
    begin
        #2000000;
        fails++;
        end_sim();
    end
endmodule // power_mode_domain_control_bench
